// ==== rtl/afscl_pkg.sv ====
// constants, types and decoders for the automatic fan speed control loop
package afscl_pkg;

  // ----------------------------------------
  // register indices (byte address = 4 x index)
  // ----------------------------------------
  localparam logic [7:0] IDX_LOOP_CONFIG_ONE  = 8'h00;
  localparam logic [7:0] IDX_FAN_TRAITS_ONE   = 8'h20;
  localparam logic [7:0] IDX_FLOOR_DUTY       = 8'h22;
  localparam logic [7:0] IDX_LOCAL_ON_TEMP    = 8'h24;
  localparam logic [7:0] IDX_REMOTE_ON_TEMP   = 8'h25;
  localparam logic [7:0] IDX_MANUAL_DUTY      = 8'h26;
  localparam logic [7:0] IDX_LOOP_STATUS      = 8'h27;

  // ----------------------------------------
  // reset values and field positions
  // ----------------------------------------
  localparam logic [7:0] RST_LOOP_CONFIG_ONE  = 8'h80;
  localparam logic [7:0] RST_FAN_TRAITS_ONE   = 8'h1d;
  localparam logic [7:0] RST_FLOOR_DUTY       = 8'h05;
  localparam logic [7:0] RST_ON_TEMP_SPAN     = 8'h43;
  localparam logic [7:0] RST_MANUAL_DUTY      = 8'h00;
  localparam int         AUTO_BIT             = 7;
  localparam int         SEL_LSB              = 5;
  localparam int         SPIN_LSB             = 0;
  localparam int         FREQ_LSB             = 3;
  localparam int         RANGE_LSB            = 6;
  localparam int         ON_TEMP_LSB          = 3;

  // ----------------------------------------
  // loop and timing constants
  // ----------------------------------------
  localparam logic [3:0] FULL_DUTY_CODE       = 4'hf;
  localparam logic [7:0] LAST_SLOT            = 8'd239;
  localparam logic [7:0] HYST_DEG_C           = 8'd5;
  localparam int         CLK_HZ               = 40_000_000;
  localparam int         US_PER_S             = 1_000_000;
  localparam int         SLOTS_PER_PERIOD     = 240;
  localparam logic [9:0] LAST_US_OF_MS        = 10'd999;

  typedef enum logic [1:0] {FAN_IDLE, FAN_SPIN, FAN_RUN} afscl_phase_e;
  typedef enum logic [1:0] {SEL_REMOTE, SEL_LOCAL, SEL_REMOTE_ALT, SEL_FASTEST} afscl_sel_e;

  typedef struct packed {
    logic [7:0]   cfg_reg;
    logic [7:0]   traits_reg;
    logic [7:0]   floor_reg;
    logic [7:0]   local_reg;
    logic [7:0]   remote_reg;
    logic [7:0]   manual_reg;
    logic [11:0]  tick_cnt;
    logic [9:0]   ms_cnt;
    logic [8:0]   us_cnt;
    logic [7:0]   slot_idx;
    logic [13:0]  spin_ms;
    afscl_phase_e phase;
    logic         local_on;
    logic         remote_on;
    logic [3:0]   local_duty;
    logic [3:0]   remote_duty;
    logic [3:0]   duty_act;
    logic         pwm;
    logic [3:0]   tach_div;
    logic [7:0]   rdata;
  } afscl_state_s;

  // spin-up time in ms per code
  function automatic logic [13:0] spin_ms_of(input logic [2:0] code);
    unique case (code)
      3'h0: spin_ms_of = 14'd200;
      3'h1: spin_ms_of = 14'd400;
      3'h2: spin_ms_of = 14'd600;
      3'h3: spin_ms_of = 14'd800;
      3'h4: spin_ms_of = 14'd1000;
      3'h5: spin_ms_of = 14'd2000;
      3'h6: spin_ms_of = 14'd4000;
      3'h7: spin_ms_of = 14'd8000;
    endcase
  endfunction

  // pwm frequency in millihertz per code
  function automatic int freq_mhz_of(input logic [2:0] code);
    unique case (code)
      3'h0: freq_mhz_of = 11700;
      3'h1: freq_mhz_of = 15600;
      3'h2: freq_mhz_of = 23400;
      3'h3: freq_mhz_of = 31250;
      3'h4: freq_mhz_of = 37500;
      3'h5: freq_mhz_of = 46900;
      3'h6: freq_mhz_of = 62500;
      3'h7: freq_mhz_of = 93500;
    endcase
  endfunction
endpackage

// ==== rtl/afscl_top.sv ====
// automatic fan speed control loop with apb register bank and pwm output
`timescale 1ns/1ps

// Summary of operation
// - config bit 7 high runs automatic control, low uses software duty; resets high.
// - select 00 remote loop drives fan; 11 fastest of local and remote drives.
// - spin-up field codes 0..7 give 200 ms to 8 s; default code 101.
// - frequency field codes 0..7 give 11.7 to 93.5 Hz; default 31.25 Hz.
// - speed-range field selects tach divisor 1, 2, 4 or 8.
// - floor duty nibble applies at turn-on temperature; resets to 5.
// - duty code k gives k/15 of the pwm period.
// - duty rises linearly, reaching full at on-temp plus (15-floor) times span/10.
// - on-temp field is code times 4 degrees; default 32 degrees.
// - span codes 0..4 give 5, 10, 20, 40, 80 degrees.
// - fan keeps running until temperature drops more than 5 degrees below on-temp.
// - remote channel has its own on-temp and span with the same encoding.
// - on first exceeding on-temp the fan spins up for the set time.
module afscl_top
  import afscl_pkg::*;
#(
  parameter int TICK_CYC = CLK_HZ / US_PER_S
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [9:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  local_temp,
  input  wire logic [7:0]  remote_temp,
  input  wire logic        temp_valid,
  output logic             pwm_out,
  output logic      [3:0]  tach_divisor
);

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (TICK_CYC < 1 || TICK_CYC > 4095)
  begin : g_bad_tick
    $error("TICK_CYC out of range");
  end

  localparam logic [11:0] LAST_TICK = 12'(TICK_CYC - 1);

  // ----------------------------------------
  // channel loop calculation
  // ----------------------------------------
  // fixed shift replaces a divider: span/10 is a power of two per code
  function automatic logic [3:0] chan_duty(input logic [7:0] temp,
                                           input logic [7:0] cfg,
                                           input logic [3:0] floor_code);
    logic [7:0] on_temp;
    logic [8:0] steps;
    logic [9:0] sum;
    on_temp = {1'b0, cfg[7:ON_TEMP_LSB], 2'b00};
    steps   = '0;
    sum     = '0;
    if (temp > on_temp)
    begin
      unique case (cfg[2:0])
        3'h0:    steps = {temp - on_temp, 1'b0};
        3'h1:    steps = {1'b0, temp - on_temp};
        3'h2:    steps = {2'b00, 7'((temp - on_temp) >> 1)};
        3'h3:    steps = {3'b000, 6'((temp - on_temp) >> 2)};
        default: steps = {4'h0, 5'((temp - on_temp) >> 3)};
      endcase
    end
    sum = {6'h00, floor_code} + {1'b0, steps};
    chan_duty = (sum > {6'h00, FULL_DUTY_CODE}) ? FULL_DUTY_CODE : sum[3:0];
  endfunction

  function automatic logic chan_on(input logic [7:0] temp,
                                   input logic [7:0] cfg,
                                   input logic       was_on);
    logic [8:0] on_temp;
    on_temp = {2'b00, cfg[7:ON_TEMP_LSB], 2'b00};
    if ({1'b0, temp} > on_temp)
      chan_on = 1'b1;
    else if ({1'b0, temp} + {1'b0, HYST_DEG_C} < on_temp)
      chan_on = 1'b0;
    else
      chan_on = was_on;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  afscl_state_s st_reg;
  afscl_state_s st_next;
  logic         tick;
  logic         ms_tick;
  logic         wrap;
  logic         auto_mode;
  logic         fan_on;
  logic [3:0]   target;
  logic [3:0]   eff_duty;
  logic [8:0]   slot_len;
  logic [7:0]   idx;
  logic         mapped;
  logic         wr_en;
  afscl_sel_e   sel;

  localparam afscl_state_s ST_RESET = '{
    cfg_reg:    RST_LOOP_CONFIG_ONE,
    traits_reg: RST_FAN_TRAITS_ONE,
    floor_reg:  RST_FLOOR_DUTY,
    local_reg:  RST_ON_TEMP_SPAN,
    remote_reg: RST_ON_TEMP_SPAN,
    manual_reg: RST_MANUAL_DUTY,
    tach_div:   4'h1,
    phase:      FAN_IDLE,
    default:    '0
  };

  assign idx    = paddr[9:2];
  assign mapped = (idx == IDX_LOOP_CONFIG_ONE) || (idx == IDX_FAN_TRAITS_ONE) ||
                  (idx == IDX_FLOOR_DUTY) || (idx == IDX_LOCAL_ON_TEMP) ||
                  (idx == IDX_REMOTE_ON_TEMP) || (idx == IDX_MANUAL_DUTY) ||
                  (idx == IDX_LOOP_STATUS);
  assign wr_en  = psel && penable && pwrite && mapped;

  // zero wait states: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = {24'h000000, st_reg.rdata};
  assign pwm_out = st_reg.pwm;
  assign tach_divisor = st_reg.tach_div;

  assign auto_mode = st_reg.cfg_reg[AUTO_BIT];
  assign sel       = afscl_sel_e'(st_reg.cfg_reg[SEL_LSB +: 2]);
  assign slot_len  = 9'(US_PER_S * 1000 / (SLOTS_PER_PERIOD *
                        freq_mhz_of(st_reg.traits_reg[FREQ_LSB +: 3])));
  assign tick      = (st_reg.tick_cnt == LAST_TICK);
  assign ms_tick   = tick && (st_reg.ms_cnt == LAST_US_OF_MS);
  assign wrap      = tick && (st_reg.us_cnt == slot_len - 9'd1) && (st_reg.slot_idx == LAST_SLOT);

  // ----------------------------------------
  // channel combination
  // ----------------------------------------
  always_comb
  begin
    unique case (sel)
      SEL_LOCAL:
      begin
        fan_on = st_reg.local_on;
        target = st_reg.local_duty;
      end
      SEL_FASTEST:
      begin
        fan_on = st_reg.local_on || st_reg.remote_on;
        target = (st_reg.local_duty > st_reg.remote_duty) ? st_reg.local_duty : st_reg.remote_duty;
      end
      default:
      begin
        fan_on = st_reg.remote_on;
        target = st_reg.remote_duty;
      end
    endcase
    if (!auto_mode)
      eff_duty = st_reg.manual_reg[3:0];
    else if (st_reg.phase == FAN_SPIN)
      eff_duty = FULL_DUTY_CODE;
    else
      eff_duty = target;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    st_next = st_reg;
    st_next.tick_cnt = tick ? 12'h000 : st_reg.tick_cnt + 12'h001;
    if (tick)
    begin
      st_next.ms_cnt = (st_reg.ms_cnt == LAST_US_OF_MS) ? 10'h000 : st_reg.ms_cnt + 10'h001;
      if (st_reg.us_cnt >= slot_len - 9'd1)
      begin
        st_next.us_cnt   = 9'h000;
        st_next.slot_idx = (st_reg.slot_idx == LAST_SLOT) ? 8'h00 : st_reg.slot_idx + 8'h01;
      end
      else
        st_next.us_cnt = st_reg.us_cnt + 9'h001;
    end
    if (wrap)
      st_next.duty_act = eff_duty;
    st_next.pwm = st_reg.slot_idx < {st_reg.duty_act, 4'h0};
    st_next.tach_div = 4'(1 << st_reg.traits_reg[RANGE_LSB +: 2]);
    if (temp_valid)
    begin
      st_next.local_on    = chan_on(local_temp, st_reg.local_reg, st_reg.local_on);
      st_next.remote_on   = chan_on(remote_temp, st_reg.remote_reg, st_reg.remote_on);
      st_next.local_duty  = st_next.local_on ?
                            chan_duty(local_temp, st_reg.local_reg, st_reg.floor_reg[3:0]) : 4'h0;
      st_next.remote_duty = st_next.remote_on ?
                            chan_duty(remote_temp, st_reg.remote_reg, st_reg.floor_reg[3:0]) : 4'h0;
    end
    unique case (st_reg.phase)
      FAN_IDLE:
        if (auto_mode && fan_on)
        begin
          st_next.phase   = FAN_SPIN;
          st_next.spin_ms = spin_ms_of(st_reg.traits_reg[SPIN_LSB +: 3]);
        end
      FAN_SPIN:
        if (!auto_mode || !fan_on)
          st_next.phase = FAN_IDLE;
        else if (ms_tick)
        begin
          st_next.spin_ms = st_reg.spin_ms - 14'h0001;
          if (st_reg.spin_ms == 14'h0001)
            st_next.phase = FAN_RUN;
        end
      FAN_RUN:
        if (!auto_mode || !fan_on)
          st_next.phase = FAN_IDLE;
      // the fourth code of the phase field is never entered; fall back to idle
      default:
        st_next.phase = FAN_IDLE;
    endcase
    if (wr_en)
    begin
      unique case (idx)
        IDX_LOOP_CONFIG_ONE: st_next.cfg_reg    = pwdata[7:0];
        IDX_FAN_TRAITS_ONE:  st_next.traits_reg = pwdata[7:0];
        IDX_FLOOR_DUTY:      st_next.floor_reg  = {4'h0, pwdata[3:0]};
        IDX_LOCAL_ON_TEMP:   st_next.local_reg  = pwdata[7:0];
        IDX_REMOTE_ON_TEMP:  st_next.remote_reg = pwdata[7:0];
        IDX_MANUAL_DUTY:     st_next.manual_reg = {4'h0, pwdata[3:0]};
        default:             st_next.cfg_reg    = st_reg.cfg_reg;
      endcase
    end
    // read data captured in the setup cycle
    if (psel && !penable && !pwrite)
    begin
      unique case (idx)
        IDX_LOOP_CONFIG_ONE: st_next.rdata = st_reg.cfg_reg;
        IDX_FAN_TRAITS_ONE:  st_next.rdata = st_reg.traits_reg;
        IDX_FLOOR_DUTY:      st_next.rdata = st_reg.floor_reg;
        IDX_LOCAL_ON_TEMP:   st_next.rdata = st_reg.local_reg;
        IDX_REMOTE_ON_TEMP:  st_next.rdata = st_reg.remote_reg;
        IDX_MANUAL_DUTY:     st_next.rdata = st_reg.manual_reg;
        IDX_LOOP_STATUS:     st_next.rdata = {st_reg.local_on, st_reg.remote_on,
                                              st_reg.phase, st_reg.duty_act};
        default:             st_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_reg <= ST_RESET;
    else
      st_reg <= st_next;
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_MANUAL_DUTY: assert property (!auto_mode |-> eff_duty == st_reg.manual_reg[3:0])
    else $error("manual mode duty mismatch");
  AST_FASTEST: assert property (auto_mode && sel == SEL_FASTEST
    |-> target >= st_reg.local_duty && target >= st_reg.remote_duty &&
        (target == st_reg.local_duty || target == st_reg.remote_duty) &&
        (st_reg.phase == FAN_SPIN || eff_duty == target))
    else $error("fastest loop not applied");
  AST_SPIN_FULL: assert property (auto_mode && st_reg.phase == FAN_SPIN |-> eff_duty == FULL_DUTY_CODE)
    else $error("spin-up not at full duty");
  AST_SPIN_START: assert property (auto_mode && fan_on && st_reg.phase == FAN_IDLE
    |=> st_reg.phase == FAN_SPIN && st_reg.spin_ms == spin_ms_of($past(st_reg.traits_reg[2:0])))
    else $error("spin-up did not start");
  AST_DUTY_AT_WRAP: assert property ($changed(st_reg.duty_act) |-> $past(wrap))
    else $error("duty changed inside a period");
  AST_SLOT_BOUND: assert property (st_reg.slot_idx <= LAST_SLOT)
    else $error("slot index past period end");
  AST_PWM_ZERO: assert property (st_reg.duty_act == 4'h0 |=> !pwm_out)
    else $error("pwm high at zero duty");
  AST_TACH_DIV: assert property (##1 tach_divisor == 4'(1 << $past(st_reg.traits_reg[7:6])))
    else $error("tach divisor mismatch");
  AST_HYST_HOLD: assert property (temp_valid && st_reg.local_on &&
    {1'b0, local_temp} + 9'd5 >= {2'b00, st_reg.local_reg[7:3], 2'b00} |=> st_reg.local_on)
    else $error("fan stopped inside hysteresis band");
  AST_FLOOR: assert property (temp_valid &&
    {1'b0, local_temp} + 9'd5 >= {2'b00, st_reg.local_reg[7:3], 2'b00} &&
    local_temp <= {st_reg.local_reg[7:3], 2'b00} && st_reg.local_on
    |=> st_reg.local_duty == $past(st_reg.floor_reg[3:0]))
    else $error("floor duty not applied at turn-on temperature");

endmodule

// ==== test/afscl_fan_model.sv ====
// temperature sensor and fan model facing the fan control loop
`timescale 1ns/1ps
module afscl_fan_model
  import afscl_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [7:0] local_set,
  input  wire logic [7:0] remote_set,
  input  wire logic       pwm_out,
  output logic      [7:0] local_temp,
  output logic      [7:0] remote_temp,
  output logic            temp_valid,
  output logic            fan_fed
);
  logic [2:0] conv_cnt;

  // ----------------------------------------
  // conversions
  // ----------------------------------------
  // a result every 8 cycles; values hold between pulses like a real result register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      conv_cnt    <= 3'h0;
      temp_valid  <= 1'b0;
      local_temp  <= 8'h00;
      remote_temp <= 8'h00;
    end
    else
    begin
      conv_cnt   <= conv_cnt + 3'h1;
      temp_valid <= (conv_cnt == 3'h7);
      if (conv_cnt == 3'h7)
      begin
        local_temp  <= local_set;
        remote_temp <= remote_set;
      end
    end
  end

  // ----------------------------------------
  // fan
  // ----------------------------------------
  // fan only sees drive while the pwm line is high; no rotor inertia modelled
  assign fan_fed = pwm_out;
endmodule

// ==== test/afscl_top_tb.sv ====
// self-checking bench for the fan control loop over apb
`timescale 1ns/1ps
module afscl_top_tb;
  import afscl_pkg::*;
  // slot length in 1 us ticks at frequency code 7, truncated
  localparam int SLOT_CYC   = 1000000000 / (240 * 93500);
  localparam int PERIOD_CYC = 240 * SLOT_CYC;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [9:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  local_temp;
  logic [7:0]  remote_temp;
  logic [7:0]  local_set;
  logic [7:0]  remote_set;
  logic        temp_valid;
  logic        pwm_out;
  logic [3:0]  tach_divisor;
  logic [31:0] rd;
  logic        err;
  int          error_cnt;
  int          n_checks;
  int          hi;
  logic [7:0]  rst_idx [5] = '{8'h00, 8'h20, 8'h22, 8'h24, 8'h25};
  logic [7:0]  rst_val [5] = '{8'h80, 8'h1d, 8'h05, 8'h43, 8'h43};
  logic [7:0]  t_loc [6] = '{8'd41, 8'd36, 8'd35, 8'd34, 8'd40, 8'd0};
  logic [7:0]  t_rem [6] = '{8'd0, 8'd0, 8'd0, 8'd0, 8'd48, 8'd49};
  logic [3:0]  t_sts [6] = '{4'h8, 4'h8, 4'h8, 4'h0, 4'h0, 4'h5};

  afscl_top #(.TICK_CYC(1)) i_afscl_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .local_temp(local_temp), .remote_temp(remote_temp), .temp_valid(temp_valid), .pwm_out(pwm_out),
    .tach_divisor(tach_divisor));
  afscl_fan_model i_afscl_fan_model (.pclk(pclk), .presetn(presetn), .local_set(local_set),
    .remote_set(remote_set), .pwm_out(pwm_out), .local_temp(local_temp), .remote_temp(remote_temp),
    .temp_valid(temp_valid), .fan_fed());

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task bad(input string what);
    error_cnt++;
    $display("mismatch at %0t: %s", $time, what);
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp)
      bad($sformatf("%s got %h exp %h", what, got, exp));
  endtask

  // one apb transfer, entered and left just after a rising edge
  task apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    int i;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (i == 20)
    begin
      bad("apb answer missing");
      stop_test;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // cycles of the next high pulse, capped at two periods
  task meas_high(output int n);
    int i;
    n = 0;
    for (i = 0; i < 2 * PERIOD_CYC && pwm_out !== 1'b1; i++)
      @(posedge pclk);
    if (pwm_out !== 1'b1)
    begin
      bad("pwm never rose");
      stop_test;
    end
    while (pwm_out === 1'b1 && n < 2 * PERIOD_CYC)
    begin
      @(posedge pclk);
      n++;
    end
  endtask

  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h000;
    pwdata = 32'h0;
    local_set = 8'h00;
    remote_set = 8'h00;
    error_cnt = 0;
    n_checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, rst_idx[i], 32'h0);
      chk(rd, {24'h0, rst_val[i]}, "reset value");
    end
    chk({28'h0, tach_divisor}, 32'h1, "divisor after reset");
    // unmapped place: write dropped, read zero with error
    apb(1'b1, 8'h01, 32'hff);
    apb(1'b0, 8'h01, 32'h0);
    chk({rd[30:0], err}, 32'h1, "unmapped read");
    for (int c = 0; c < 4; c++)
    begin
      apb(1'b1, IDX_FAN_TRAITS_ONE, {24'h0, c[1:0], 3'h7, 3'h0});
      apb(1'b0, IDX_FAN_TRAITS_ONE, 32'h0);
      chk(rd, {24'h0, c[1:0], 3'h7, 3'h0}, "traits readback");
      chk({28'h0, tach_divisor}, 32'h1 << c, "divisor");
    end
    // software duty: pulse width per code at 93.5 Hz
    apb(1'b1, IDX_LOOP_CONFIG_ONE, 32'h0);
    for (int k = 5; k < 15; k += 9)
    begin
      apb(1'b1, IDX_MANUAL_DUTY, k);
      meas_high(hi);
      chk(hi, 16 * k * SLOT_CYC, "manual duty width");
    end
    apb(1'b1, IDX_MANUAL_DUTY, 32'h0);
    // loop set up in order, automatic bit last
    apb(1'b1, IDX_LOCAL_ON_TEMP, 32'h50);
    apb(1'b1, IDX_REMOTE_ON_TEMP, 32'h60);
    apb(1'b1, IDX_FAN_TRAITS_ONE, 32'hf8);
    apb(1'b1, IDX_LOOP_CONFIG_ONE, 32'h00);
    apb(1'b1, IDX_LOOP_CONFIG_ONE, 32'h80);
    for (int i = 0; i < 6; i++)
    begin
      local_set  <= t_loc[i];
      remote_set <= t_rem[i];
      repeat (24) @(posedge pclk);
      apb(1'b0, IDX_LOOP_STATUS, 32'h0);
      chk({28'h0, rd[7:4]}, {28'h0, t_sts[i]}, "on state and phase");
    end
    // spin-up lasts 200 ms, far beyond two periods of full drive
    meas_high(hi);
    chk(hi, 2 * PERIOD_CYC, "spin-up drive");
    // select 11: either loop keeps the fan on, so the hand-over to local alone keeps spinning
    apb(1'b1, IDX_LOOP_CONFIG_ONE, 32'he0);
    local_set  <= 8'd45;
    remote_set <= 8'd0;
    repeat (24) @(posedge pclk);
    apb(1'b0, IDX_LOOP_STATUS, 32'h0);
    chk({28'h0, rd[7:4]}, 32'h9, "fastest select status");
    apb(1'b1, IDX_LOOP_CONFIG_ONE, 32'h80);
    apb(1'b0, IDX_LOOP_STATUS, 32'h0);
    chk({28'h0, rd[7:4]}, 32'h8, "remote select status");
    apb(1'b1, IDX_LOOP_CONFIG_ONE, 32'ha0);
    apb(1'b0, IDX_LOOP_STATUS, 32'h0);
    chk({28'h0, rd[7:4]}, 32'h9, "local select spin restart");
    stop_test;
  end
endmodule
